// ===== rtl/bvdc_top.sv
/*
 Setpoint and slew control of the step-down regulator, reached over a
 classic Wishbone slave. Assumes RESET marks main-supply power-up and
 RUN arrives asynchronously from a pin.
*/
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module bvdc_top
   import bvdc_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        RUN,
   output logic             BUCK_EN,
   output logic      [5:0]  DAC_CODE,
   output logic      [1:0]  SLEW_SEL,
   output logic             RAMPING
);

   logic        req;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        wr_fire;
   logic        wr_setpoint;
   logic        wr_slew;
   logic        wr_update;
   logic        commit;
   logic [5:0]  setpoint_q;
   logic [1:0]  slew_q;
   logic        go_q;
   logic [5:0]  target_q;
   logic [1:0]  slew_act_q;
   logic        run_meta_q;
   logic        run_sync_q;
   logic        en_q;
   logic [5:0]  dac_code;
   logic        ramp_busy;

   // Register selection, shared by read and write paths
   function automatic logic hit(input logic [3:0] adr,
                                input logic [3:0] ofs);
      return (adr[3:2] == ofs[3:2]);
   endfunction

   // Bus request present
   assign req = WB_CYC_I && WB_STB_I;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // Read data captured with the ack; bits outside the register fields read zero
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         dat_q <= 32'h0000_0000;
      end else if (req && !ack_q) begin
         dat_q <= 32'h0000_0000;
         if (hit(WB_ADR_I, OFS_SETPOINT)) begin
            dat_q[5:0] <= setpoint_q;
         end
         if (hit(WB_ADR_I, OFS_SLEW)) begin
            dat_q[1:0] <= slew_q;
         end
         if (hit(WB_ADR_I, OFS_UPDATE)) begin
            dat_q[UPD_GO_BIT] <= go_q;
         end
         if (hit(WB_ADR_I, OFS_STATUS)) begin
            dat_q[STAT_TARGET_LSB +: 6] <= target_q;
            dat_q[STAT_DAC_LSB +: 6]    <= dac_code;
            dat_q[STAT_SLEW_LSB +: 2]   <= slew_act_q;
            dat_q[STAT_RAMP_BIT]        <= ramp_busy;
            dat_q[STAT_RUN_BIT]         <= run_sync_q;
         end
      end
   end

   assign WB_DAT_O = dat_q;
   assign WB_ACK_O = ack_q;

   // Writes land only on the edge that the master sees ack
   assign wr_fire     = req && WB_WE_I && ack_q && WB_SEL_I[0];
   assign wr_setpoint = wr_fire && hit(WB_ADR_I, OFS_SETPOINT);
   assign wr_slew     = wr_fire && hit(WB_ADR_I, OFS_SLEW);
   assign wr_update   = wr_fire && hit(WB_ADR_I, OFS_UPDATE);
   // Only a low-to-high move of the stored bit commits
   assign commit      = wr_update && WB_DAT_I[UPD_GO_BIT] && !go_q;

   // Programmed setpoint; raw value kept so software reads back its write
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         setpoint_q <= CODE_DEFAULT;
      end else if (wr_setpoint) begin
         setpoint_q <= WB_DAT_I[5:0];
      end
   end

   // Programmed slew selector; untouched by RUN
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         slew_q <= SLEW_DEFAULT;
      end else if (wr_slew) begin
         slew_q <= WB_DAT_I[1:0];
      end
   end

   // Update bit as last written
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         go_q <= 1'b0;
      end else if (wr_update) begin
         go_q <= WB_DAT_I[UPD_GO_BIT];
      end
   end

   // Shadow copies; clamping here keeps codes above 48 out of the DAC
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         target_q   <= CODE_DEFAULT;
         slew_act_q <= SLEW_DEFAULT;
      end else if (commit) begin
         target_q   <= bvdc_clamp(setpoint_q);
         slew_act_q <= slew_q;
      end
   end

   // RUN pin synchroniser
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         run_meta_q <= 1'b0;
         run_sync_q <= 1'b0;
      end else begin
         run_meta_q <= RUN;
         run_sync_q <= run_meta_q;
      end
   end

   // Enable follows RUN; settings stay put while off
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         en_q <= 1'b0;
      end else begin
         en_q <= run_sync_q;
      end
   end

   assign BUCK_EN  = en_q;
   assign SLEW_SEL = slew_act_q;

   // Ramp engine; paused while the regulator is off
   bvdc_ramp u_ramp (
      .clk      (CORE_CLK),
      .rst      (RESET),
      .target   (target_q),
      .rate_sel (slew_act_q),
      .run      (run_sync_q),
      .code_q   (dac_code),
      .busy_q   (ramp_busy)
   );

   assign DAC_CODE = dac_code;
   assign RAMPING  = ramp_busy;

   // Commit: update rising edge, then shadow loaded
   sequence s_go_rise;
      wr_update && WB_DAT_I[UPD_GO_BIT] && !go_q;
   endsequence

   sequence s_shadow_loaded(logic [5:0] sp, logic [1:0] sl);
      target_q == bvdc_clamp(sp) && slew_act_q == sl;
   endsequence

   property p_commit;
      logic [5:0] sp;
      logic [1:0] sl;
      (s_go_rise, sp = setpoint_q, sl = slew_q) |=> s_shadow_loaded(sp, sl);
   endproperty

   a_commit_on_rise: assert property (@(posedge CORE_CLK)
      disable iff (RESET) p_commit)
      else $error("update edge did not commit");

   // Shadow holds until the next commit
   a_shadow_stable: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      !commit |=> $stable(target_q) && $stable(slew_act_q))
      else $error("shadow changed without commit");

   // Writing a one over a one must not commit again
   a_no_level_commit: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (wr_update && go_q) |=> $stable(target_q) && $stable(slew_act_q))
      else $error("commit on a level, not an edge");

   // Target never beyond the top code
   a_clamp_target: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      target_q <= CODE_MAX && DAC_CODE <= CODE_MAX)
      else $error("code above clamp limit");

   // Oversize write commits as the top code
   a_clamp_commit: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (commit && setpoint_q > CODE_MAX) |=> target_q == CODE_MAX)
      else $error("oversize code not clamped");

   // Setpoint stored only by an acknowledged write
   a_write_needs_ack: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      !$stable(setpoint_q) |-> $past(wr_setpoint) && $past(ack_q))
      else $error("setpoint written without ack");

   // Acknowledged write stores the data
   a_write_stores: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      wr_setpoint |=> setpoint_q == $past(WB_DAT_I[5:0]))
      else $error("setpoint write lost");

   // Ack is a single cycle answering a request one cycle late
   a_ack_pulse: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (req && !ack_q) |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not a one-cycle answer");

   // Run dropping keeps both settings
   a_run_retains: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      ($fell(run_sync_q) && !wr_setpoint && !wr_slew && !commit)
      |=> $stable(setpoint_q) && $stable(slew_q) && $stable(target_q))
      else $error("settings lost on run low");

   // Defaults right after power-up
   a_reset_defaults: assert property (@(posedge CORE_CLK)
      $fell(RESET) |-> target_q == CODE_DEFAULT
      && slew_act_q == SLEW_DEFAULT && DAC_CODE == CODE_DEFAULT)
      else $error("wrong power-up defaults");

   // Off regulator does not move the code
   a_frozen_off: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      !run_sync_q |=> $stable(DAC_CODE))
      else $error("code moved while off");

   // An ack only ever answers a live request
   a_ack_answers: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      WB_ACK_O |-> $past(req))
      else $error("ack without a request");

   // A write with byte lane 0 off leaves every field alone
   a_lane_guard: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (req && WB_WE_I && ack_q && !WB_SEL_I[0])
      |=> $stable(setpoint_q) && $stable(slew_q) && $stable(go_q))
      else $error("masked write changed a field");

   // Update bit keeps what was last written, so a level cannot recommit
   a_go_stores: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      wr_update |=> go_q == $past(WB_DAT_I[UPD_GO_BIT]))
      else $error("update bit write lost");

   // Acknowledged slew write stores the selector
   a_slew_stores: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      wr_slew |=> slew_q == $past(WB_DAT_I[1:0]))
      else $error("slew write lost");

   // Enable is the synchronised RUN one cycle later
   a_en_follows: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      BUCK_EN == $past(run_sync_q))
      else $error("enable does not follow run");

   // Any gap between code and target shows as ramping
   a_busy_flag: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (DAC_CODE != target_q) |=> RAMPING)
      else $error("ramping flag missed a move");

   // Status read returns the committed target, not the raw code
   a_status_target: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (req && !ack_q && !WB_WE_I && hit(WB_ADR_I, OFS_STATUS))
      |=> WB_DAT_O[STAT_TARGET_LSB +: 6] == $past(target_q))
      else $error("status read lost the target");

   // Setpoint read returns the raw stored code, even above the clamp
   a_setpoint_read: assert property (@(posedge CORE_CLK)
      disable iff (RESET)
      (req && !ack_q && !WB_WE_I && hit(WB_ADR_I, OFS_SETPOINT))
      |=> WB_DAT_O[5:0] == $past(setpoint_q))
      else $error("setpoint read lost the code");

endmodule // bvdc_top

// ===== common/bvdc_pkg.sv
/*
 Constants, field layout and shared helpers for the buck setpoint control.
 Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package bvdc_pkg;

   // Clock and code geometry
   localparam int unsigned CLK_MHZ         = 40;
   localparam int unsigned CODE_W          = 6;
   localparam logic [5:0]  CODE_MAX        = 6'h30;
   // Output span in millivolts
   localparam int unsigned BUCK_OUTPUT_MIN_MV     = 850;
   localparam int unsigned BUCK_OUTPUT_MAX_MV     = 1550;
   localparam int unsigned BUCK_OUTPUT_DEFAULT_MV = 1350;
   // Microvolts per code step, about 14.6 mV
   localparam int unsigned STEP_UV         =
      (BUCK_OUTPUT_MAX_MV - BUCK_OUTPUT_MIN_MV) * 1000 / 48;
   localparam int unsigned CODE_DEFAULT_I  =
      (BUCK_OUTPUT_DEFAULT_MV - BUCK_OUTPUT_MIN_MV) * 1000 / STEP_UV;
   localparam logic [5:0]  CODE_DEFAULT    = CODE_DEFAULT_I[5:0];
   // Ramp rates in microvolts per microsecond
   localparam int unsigned RATE0_UV_US     = 900;
   localparam int unsigned RATE1_UV_US     = 3800;
   localparam int unsigned RATE2_UV_US     = 7500;
   localparam int unsigned RATE3_UV_US     = 11300;
   // Fastest rate is nearest the 10 mV/us default
   localparam logic [1:0]  SLEW_DEFAULT    = 2'h3;
   // Cycles per code step, rounded down
   localparam int unsigned STEP_CYC0 = STEP_UV * CLK_MHZ / RATE0_UV_US;
   localparam int unsigned STEP_CYC1 = STEP_UV * CLK_MHZ / RATE1_UV_US;
   localparam int unsigned STEP_CYC2 = STEP_UV * CLK_MHZ / RATE2_UV_US;
   localparam int unsigned STEP_CYC3 = STEP_UV * CLK_MHZ / RATE3_UV_US;
   localparam int unsigned STEP_CYC_W = 10;

   // Register byte offsets
   localparam logic [3:0]  OFS_SETPOINT    = 4'h0;
   localparam logic [3:0]  OFS_SLEW        = 4'h4;
   localparam logic [3:0]  OFS_UPDATE      = 4'h8;
   localparam logic [3:0]  OFS_STATUS      = 4'hc;
   // Field positions
   localparam int unsigned UPD_GO_BIT      = 0;
   localparam int unsigned STAT_TARGET_LSB = 0;
   localparam int unsigned STAT_DAC_LSB    = 8;
   localparam int unsigned STAT_SLEW_LSB   = 16;
   localparam int unsigned STAT_RAMP_BIT   = 24;
   localparam int unsigned STAT_RUN_BIT    = 25;

   // Clamp a raw code into the usable range
   function automatic logic [5:0] bvdc_clamp(input logic [5:0] raw);
      return (raw > CODE_MAX) ? CODE_MAX : raw;
   endfunction

   // Cycles per code step for a selector; the counter reloads with one less
   function automatic logic [STEP_CYC_W-1:0] bvdc_step_cyc(
      input logic [1:0] sel);
      logic [STEP_CYC_W-1:0] n;
      unique case (sel)
         2'h0: n = STEP_CYC_W'(STEP_CYC0);
         2'h1: n = STEP_CYC_W'(STEP_CYC1);
         2'h2: n = STEP_CYC_W'(STEP_CYC2);
         2'h3: n = STEP_CYC_W'(STEP_CYC3);
      endcase
      return n;
   endfunction

endpackage

// ===== rtl/bvdc_ramp.sv
/*
 Slew engine: walks the applied DAC code one step at a time toward the
 committed target at the selected rate. Assumes target and rate come
 from flops in the same clock domain and run is already synchronised.
*/
`timescale 1ns/1ps
module bvdc_ramp
   import bvdc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  target,
   input  wire logic [1:0]  rate_sel,
   input  wire logic        run,
   output logic      [5:0]  code_q,
   output logic             busy_q
);

   logic [STEP_CYC_W-1:0] cnt_q;
   logic                  step;

   // First step is immediate, later ones wait a full dwell
   assign step = run && (code_q != target) && (cnt_q == '0);

   // Dwell counter per code step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!run || code_q == target) begin
         cnt_q <= '0;
      end else if (cnt_q == '0) begin
         cnt_q <= bvdc_step_cyc(rate_sel) - STEP_CYC_W'(1);
      end else begin
         cnt_q <= cnt_q - STEP_CYC_W'(1);
      end
   end

   // Applied code, one step toward target
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_q <= CODE_DEFAULT;
      end else if (step) begin
         code_q <= (code_q < target) ? code_q + 6'h01
                                     : code_q - 6'h01;
      end
   end

   // Ramp in progress flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (code_q != target);
      end
   end

   // Each change is a single step toward the target
   a_ramp_one_step: assert property (@(posedge clk) disable iff (rst)
      (code_q != $past(code_q)) |->
      ((code_q == $past(code_q) + 6'h01 && $past(code_q) < $past(target))
      || (code_q == $past(code_q) - 6'h01
          && $past(code_q) > $past(target))))
      else $error("ramp moved by more than one step");

   // Even the fastest rate leaves eight quiet cycles after a step
   a_ramp_dwell: assert property (@(posedge clk) disable iff (rst)
      step |=> !step [*8])
      else $error("ramp stepped too soon");

endmodule // bvdc_ramp

// ===== dv/bvdc_wb_host.sv
/*
 Classic Wishbone master model standing in for the setpoint host.
 Assumes a slave that answers each request with a one-cycle ack.
*/
`timescale 1ns/1ps
module bvdc_wb_host (
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] dat_o,
   output logic             cyc = 1'b0,
   output logic             stb = 1'b0,
   output logic             we = 1'b0,
   output logic      [3:0]  adr = 4'h0,
   output logic      [3:0]  sel = 4'h0,
   output logic      [31:0] dat = 32'h0,
   output logic             hung = 1'b0
);
   // One cycle, held whole until ack is sampled high
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // No ack means a hung slave; the bench closes the run
      if (ack !== 1'b1) hung <= 1'b1;
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
endmodule // bvdc_wb_host

// ===== dv/testbench.sv
/*
 Self-checking bench for the buck setpoint control.
 Assumes the host model in dv/ and the design under rtl/.
*/
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        run = 1'b0;
   logic        cyc, stb, we, ack, buck_en, ramping, hung;
   logic [3:0]  adr, sel;
   logic [31:0] dat_i, dat_o;
   logic [5:0]  dac_code, v;
   logic [1:0]  slew_sel;
   int          fails = 0;
   int          n_compared = 0;
   int          c;
   int          rate [4] = '{648, 153, 77, 51};

   // 40 MHz core clock
   always #12.5 clk = ~clk;

   bvdc_wb_host u_host (.clk(clk), .ack(ack), .dat_o(dat_o), .cyc(cyc),
      .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat_i), .hung(hung));

   bvdc_top u_dut (.CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .RUN(run),
      .BUCK_EN(buck_en), .DAC_CODE(dac_code), .SLEW_SEL(slew_sel),
      .RAMPING(ramping));

   task automatic results;
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
      logic [31:0] q;
      u_host.xfer(1'b1, a, s, d, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_host.xfer(1'b0, a, 4'hf, 32'h0, q);
      chk("read data", q, e);
   endtask

   // Cycles until the applied code next moves, seen at falling edges
   task automatic to_step(output int n);
      logic [5:0] p;
      p = dac_code;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (dac_code === p && n < 2000);
      if (n >= 2000) begin
         fails++;
         results();
      end
   endtask

   // Bounded wait for the ramp to land on a code
   task automatic settle(input logic [5:0] e);
      for (int i = 0; i < 3000 && dac_code !== e; i++) @(negedge clk);
      chk("DAC_CODE", dac_code, e);
   endtask

   // A slave that never acks ends the run as a failure
   always @(posedge hung) begin
      fails++;
      results();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("DAC_CODE", dac_code, 32'h22);
      chk("SLEW_SEL", slew_sel, 32'h3);
      rd(4'h0, 32'h22);
      rd(4'h4, 32'h3);
      rd(4'h8, 32'h0);
      @(posedge clk);
      run <= 1'b1;
      repeat (4) @(negedge clk);
      chk("BUCK_EN", buck_en, 32'h1);
      // Raw code above the clamp is stored but not applied yet
      wr(4'h0, 32'h3f);
      rd(4'h0, 32'h3f);
      rd(4'hc, 32'h0203_2222);
      wr(4'h4, 32'h1, 4'he);
      rd(4'h4, 32'h3);
      wr(4'h8, 32'h1);
      settle(6'h30);
      repeat (100) @(negedge clk);
      chk("RAMPING", ramping, 32'h0);
      rd(4'hc, 32'h0203_3030);
      // Go written over a stored one must not commit
      wr(4'h0, 32'h0);
      wr(4'h8, 32'h1);
      repeat (100) @(negedge clk);
      chk("DAC_CODE", dac_code, 32'h30);
      // Every selector: step spacing after a fresh commit
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, s[0] ? 32'h30 : 32'h0);
         wr(4'h4, 32'(s));
         wr(4'h8, 32'h0);
         wr(4'h8, 32'h1);
         @(negedge clk);
         chk("SLEW_SEL", slew_sel, 32'(s));
         repeat (2) to_step(c);
         chk("RAMPING", ramping, 32'h1);
         to_step(c);
         chk("step cycles", c, rate[s]);
      end
      settle(6'h30);
      // Run low freezes output and keeps settings
      wr(4'h4, 32'h1);
      @(posedge clk);
      run <= 1'b0;
      repeat (5) @(negedge clk);
      v = dac_code;
      wr(4'h0, 32'h0);
      wr(4'h8, 32'h0);
      wr(4'h8, 32'h1);
      repeat (200) @(negedge clk);
      chk("DAC_CODE", dac_code, v);
      chk("SLEW_SEL", slew_sel, 32'h1);
      chk("BUCK_EN", buck_en, 32'h0);
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h1);
      // Second power-up restores defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("DAC_CODE", dac_code, 32'h22);
      chk("SLEW_SEL", slew_sel, 32'h3);
      rd(4'h0, 32'h22);
      rd(4'h4, 32'h3);
      results();
   end
endmodule // testbench
